// [hw/tscc_timer_status_capture_compare.sv]
// Timer channel Y status and pin control, compare-C and pulse capture behind AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module tscc_timer_status_capture_compare
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AXI4-Lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Channel Y counter side
   input wire logic [7:0] chanYCounter,
   input wire logic [7:0] chanYConstantA,
   input wire logic [7:0] chanYConstantB,
   // Channel X counter and capture input
   input wire logic [7:0] chanXCounter,
   input wire logic externalResetInput,
   // Outputs
   output logic chanYOutputPin,
   output logic captureIrqRequest,
   output logic matchCSignal,
   output logic irq
);
   import tscc_pkg::*;
   function automatic logic [2:0] regIndex(input logic [7:0] addr);
      if (addr == TY_STATUS_OFFSET) return IDX_TY_STATUS;
      else if (addr == COMPARE_C_OFFSET) return IDX_COMPARE_C;
      else if (addr == CAPTURE_RISE_OFFSET) return IDX_CAPTURE_RISE;
      else if (addr == CAPTURE_FALL_OFFSET) return IDX_CAPTURE_FALL;
      else if (addr == CAPTURE_CTRL_OFFSET) return IDX_CAPTURE_CTRL;
      else if (addr == IRQ_STATUS_OFFSET) return IDX_IRQ_STATUS;
      else if (addr == IRQ_MASK_OFFSET) return IDX_IRQ_MASK;
      else return IDX_UNMAPPED;
   endfunction : regIndex
   function automatic logic applyAction(input logic cur, input logic [1:0] sel);
      case (sel)
         ACTION_LOW: return 1'b0;
         ACTION_HIGH: return 1'b1;
         ACTION_TOGGLE: return ~cur;
         default: return cur;
      endcase
   endfunction : applyAction
   logic [7:0] awAddrReg, compareCReg, captureRiseReg, captureFallReg, yCounterPrevReg, compareCSum;
   logic [31:0] wDataReg, readValue;
   logic [3:0] wStrbReg;
   logic [2:0] wrIdx, rdIdx, flagsReg, flagsArmedReg, flagSet, flagClear;
   logic [1:0] actionBReg, actionAReg;
   logic [EV_COUNT-1:0] irqStatusReg, irqStatusNext, irqMaskReg;
   logic awHeldReg, wHeldReg, wrFire, wrEn, rdFire, irqEnableReg, captureStartReg, startArmedReg;
   logic captureFlagReg, captureFlagArmedReg, eqBPrevReg, eqAPrevReg, extPrevReg, matchBEvent, matchAEvent;
   logic wrapEvent, riseEdge, fallEdge, captureTaken, captureDone, suppressC, matchCNow;
   tscc_cap_state_type capStateReg;
   assign wrFire = awHeldReg && wHeldReg;
   assign wrIdx = regIndex(awAddrReg);
   assign wrEn = wrFire && wStrbReg[0];
   assign rdFire = arvalid && arready;
   assign rdIdx = regIndex(araddr);
   // Write channel: address and data taken in either order
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         awAddrReg <= 8'h00;
         awHeldReg <= 1'b0;
         awready <= 1'b1;
         wDataReg <= 32'h0000_0000;
         wStrbReg <= 4'h0;
         wHeldReg <= 1'b0;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awAddrReg <= awaddr;
            awHeldReg <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wDataReg <= wdata;
            wStrbReg <= wstrb;
            wHeldReg <= 1'b1;
            wready <= 1'b0;
         end
         if (wrFire)
         begin
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wrIdx == IDX_UNMAPPED) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end
   // Read data assembly
   always_comb
   begin
      readValue = 32'h0000_0000;
      if (rdIdx == IDX_TY_STATUS)
         readValue[7:0] = {flagsReg, irqEnableReg, actionBReg, actionAReg};
      else if (rdIdx == IDX_COMPARE_C)
         readValue[7:0] = compareCReg;
      else if (rdIdx == IDX_CAPTURE_RISE)
         readValue[7:0] = captureRiseReg;
      else if (rdIdx == IDX_CAPTURE_FALL)
         readValue[7:0] = captureFallReg;
      else if (rdIdx == IDX_CAPTURE_CTRL)
      begin
         readValue[CAPTURE_START_BIT] = captureStartReg;
         readValue[CAPTURE_FLAG_BIT] = captureFlagReg;
      end
      else if (rdIdx == IDX_IRQ_STATUS)
         readValue[EV_COUNT-1:0] = irqStatusReg;
      else if (rdIdx == IDX_IRQ_MASK)
         readValue[EV_COUNT-1:0] = irqMaskReg;
   end
   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else
      begin
         if (rdFire)
         begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readValue;
            rresp <= (rdIdx == IDX_UNMAPPED) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   // Event detection on counter and capture input
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         eqBPrevReg <= 1'b0;
         eqAPrevReg <= 1'b0;
         yCounterPrevReg <= COUNTER_MIN;
         extPrevReg <= 1'b0;
      end
      else
      begin
         eqBPrevReg <= (chanYCounter == chanYConstantB);
         eqAPrevReg <= (chanYCounter == chanYConstantA);
         yCounterPrevReg <= chanYCounter;
         extPrevReg <= externalResetInput;
      end
   end
   assign matchBEvent = (chanYCounter == chanYConstantB) && !eqBPrevReg;
   assign matchAEvent = (chanYCounter == chanYConstantA) && !eqAPrevReg;
   assign wrapEvent = (yCounterPrevReg == COUNTER_MAX) && (chanYCounter == COUNTER_MIN);
   assign riseEdge = externalResetInput && !extPrevReg;
   assign fallEdge = !externalResetInput && extPrevReg;
   assign captureTaken = ((capStateReg == CAP_WAIT_RISE) && riseEdge) || captureDone;
   assign captureDone = (capStateReg == CAP_WAIT_FALL) && fallEdge;
   // Channel Y flags: hardware set wins over a clear in the same cycle
   assign flagSet = {matchBEvent, matchAEvent, wrapEvent};
   assign flagClear = (wrEn && wrIdx == IDX_TY_STATUS) ?
      (flagsArmedReg & ~wDataReg[MATCH_B_FLAG_BIT:WRAP_FLAG_BIT]) : 3'h0;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flagsReg <= 3'h0;
         flagsArmedReg <= 3'h0;
      end
      else
      begin
         flagsReg <= flagSet | (flagsReg & ~flagClear);
         if (rdFire && rdIdx == IDX_TY_STATUS)
            flagsArmedReg <= flagsReg;
         else if (wrEn && wrIdx == IDX_TY_STATUS)
            flagsArmedReg <= 3'h0;
      end
   end
   // Status-control writable fields
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqEnableReg <= 1'b0;
         actionBReg <= ACTION_RESET;
         actionAReg <= ACTION_RESET;
      end
      else if (wrEn && wrIdx == IDX_TY_STATUS)
      begin
         irqEnableReg <= wDataReg[CAPTURE_IRQ_ENABLE_BIT];
         actionBReg <= wDataReg[MATCH_B_ACTION_LO +: 2];
         actionAReg <= wDataReg[MATCH_A_ACTION_LO +: 2];
      end
   end
   // Output pin: match B applied after match A when both coincide
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         chanYOutputPin <= 1'b0;
      else if (matchBEvent)
         chanYOutputPin <= applyAction(matchAEvent ? applyAction(chanYOutputPin, actionAReg)
            : chanYOutputPin, actionBReg);
      else if (matchAEvent)
         chanYOutputPin <= applyAction(chanYOutputPin, actionAReg);
   end
   // Compare-C constant
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         compareCReg <= COMPARE_C_RESET;
      else if (wrEn && wrIdx == IDX_COMPARE_C)
         compareCReg <= wDataReg[7:0];
   end
   // Sum wraps at 8 bits like the counter it is compared with
   assign compareCSum = 8'(compareCReg + captureRiseReg);
   assign suppressC = (wrFire && wrIdx == IDX_COMPARE_C) || captureTaken;
   assign matchCNow = (chanXCounter == compareCSum) && !suppressC;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         matchCSignal <= 1'b0;
      else
         matchCSignal <= matchCNow;
   end
   // One-shot pulse-width capture sequence
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         capStateReg <= CAP_IDLE;
         captureRiseReg <= CAPTURE_RESET;
         captureFallReg <= CAPTURE_RESET;
      end
      else
      begin
         case (capStateReg)
            CAP_IDLE:
               if (captureStartReg)
                  capStateReg <= CAP_WAIT_RISE;
            CAP_WAIT_RISE:
               if (!captureStartReg)
                  capStateReg <= CAP_IDLE;
               else if (riseEdge)
               begin
                  captureRiseReg <= chanXCounter;
                  capStateReg <= CAP_WAIT_FALL;
               end
            CAP_WAIT_FALL:
               if (fallEdge)
               begin
                  captureFallReg <= chanXCounter;
                  capStateReg <= CAP_IDLE;
               end
               else if (!captureStartReg)
                  capStateReg <= CAP_IDLE;
            default:
               capStateReg <= CAP_IDLE;
         endcase
      end
   end
   // Capture start bit and capture flag
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         captureStartReg <= 1'b0;
         startArmedReg <= 1'b0;
         captureFlagReg <= 1'b0;
         captureFlagArmedReg <= 1'b0;
      end
      else
      begin
         if (captureDone)
            captureStartReg <= 1'b0;
         else if (wrEn && wrIdx == IDX_CAPTURE_CTRL)
         begin
            if (!wDataReg[CAPTURE_START_BIT])
               captureStartReg <= 1'b0;
            else if (startArmedReg)
               captureStartReg <= 1'b1;
         end
         if (captureDone)
            captureFlagReg <= 1'b1;
         else if (wrEn && wrIdx == IDX_CAPTURE_CTRL && captureFlagArmedReg
            && !wDataReg[CAPTURE_FLAG_BIT])
            captureFlagReg <= 1'b0;
         if (rdFire && rdIdx == IDX_CAPTURE_CTRL)
         begin
            startArmedReg <= !captureStartReg;
            captureFlagArmedReg <= captureFlagReg;
         end
         else if (wrEn && wrIdx == IDX_CAPTURE_CTRL)
         begin
            startArmedReg <= 1'b0;
            captureFlagArmedReg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         captureIrqRequest <= 1'b0;
      else
         captureIrqRequest <= captureFlagReg && irqEnableReg;
   end
   // Sticky interrupt status, cleared by reading it; new events win
   always_comb
   begin
      irqStatusNext = irqStatusReg;
      if (rdFire && rdIdx == IDX_IRQ_STATUS)
         irqStatusNext = IRQ_RESET;
      // Event order: match C, capture, wrap, match A, match B
      irqStatusNext = irqStatusNext | {matchCNow, captureDone, wrapEvent, matchAEvent, matchBEvent};
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqStatusReg <= IRQ_RESET;
         irqMaskReg <= IRQ_RESET;
         irq <= 1'b0;
      end
      else
      begin
         irqStatusReg <= irqStatusNext;
         if (wrEn && wrIdx == IDX_IRQ_MASK)
            irqMaskReg <= wDataReg[EV_COUNT-1:0];
         irq <= |(irqStatusNext & irqMaskReg);
      end
   end
endmodule : tscc_timer_status_capture_compare
`default_nettype wire

// [hw/tscc_pkg.sv]
// Constants, field layout and types of the timer status, capture and compare block
package tscc_pkg;
   // Byte addresses on the register bus
   localparam logic [7:0] TY_STATUS_OFFSET = 8'h00;
   localparam logic [7:0] COMPARE_C_OFFSET = 8'h04;
   localparam logic [7:0] CAPTURE_RISE_OFFSET = 8'h08;
   localparam logic [7:0] CAPTURE_FALL_OFFSET = 8'h0C;
   localparam logic [7:0] CAPTURE_CTRL_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h18;
   // Register indices used by the decoder
   localparam logic [2:0] IDX_TY_STATUS = 3'h0;
   localparam logic [2:0] IDX_COMPARE_C = 3'h1;
   localparam logic [2:0] IDX_CAPTURE_RISE = 3'h2;
   localparam logic [2:0] IDX_CAPTURE_FALL = 3'h3;
   localparam logic [2:0] IDX_CAPTURE_CTRL = 3'h4;
   localparam logic [2:0] IDX_IRQ_STATUS = 3'h5;
   localparam logic [2:0] IDX_IRQ_MASK = 3'h6;
   localparam logic [2:0] IDX_UNMAPPED = 3'h7;
   // Status-control field positions
   localparam int MATCH_B_FLAG_BIT = 7;
   localparam int MATCH_A_FLAG_BIT = 6;
   localparam int WRAP_FLAG_BIT = 5;
   localparam int CAPTURE_IRQ_ENABLE_BIT = 4;
   localparam int MATCH_B_ACTION_LO = 2;
   localparam int MATCH_A_ACTION_LO = 0;
   // Capture control field positions
   localparam int CAPTURE_START_BIT = 4;
   localparam int CAPTURE_FLAG_BIT = 0;
   // Interrupt status bits
   localparam int EV_MATCH_B = 0;
   localparam int EV_MATCH_A = 1;
   localparam int EV_WRAP = 2;
   localparam int EV_CAPTURE = 3;
   localparam int EV_MATCH_C = 4;
   localparam int EV_COUNT = 5;
   // Reset values
   localparam logic [1:0] ACTION_RESET = 2'h0;
   localparam logic [7:0] COMPARE_C_RESET = 8'hFF;
   localparam logic [7:0] CAPTURE_RESET = 8'h00;
   localparam logic [4:0] IRQ_RESET = 5'h00;
   // Pin action codes and counter limits
   localparam logic [1:0] ACTION_KEEP = 2'h0;
   localparam logic [1:0] ACTION_LOW = 2'h1;
   localparam logic [1:0] ACTION_HIGH = 2'h2;
   localparam logic [1:0] ACTION_TOGGLE = 2'h3;
   localparam logic [7:0] COUNTER_MAX = 8'hFF;
   localparam logic [7:0] COUNTER_MIN = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum {CAP_IDLE, CAP_WAIT_RISE, CAP_WAIT_FALL} tscc_cap_state_type;
endpackage : tscc_pkg

// [tb/tscc_timer_status_capture_compare_properties.sv]
// Port-level properties of the timer status, capture and compare block
`timescale 1ns/100ps
`default_nettype none
module tscc_timer_status_capture_compare_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register bus
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // Timer side
   input wire logic [7:0] chanYCounter,
   input wire logic [7:0] chanYConstantA,
   input wire logic [7:0] chanYConstantB,
   input wire logic externalResetInput,
   input wire logic chanYOutputPin,
   input wire logic captureIrqRequest,
   input wire logic matchCSignal,
   input wire logic irq
);
   import tscc_pkg::*;
   logic arTake;
   logic [7:0] lastAwAddr;
   // Address of the write now under way
   always_ff @(posedge clk)
   begin
      if (awvalid && awready)
         lastAwAddr <= awaddr;
   end
   logic yEqual;
   assign arTake = arvalid && arready;
   assign yEqual = (chanYCounter == chanYConstantA) || (chanYCounter == chanYConstantB);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_write_answered: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write not answered");
   a_busy_during_resp: assert property (bvalid |-> !awready && !wready)
      else $error("write channels ready during response");
   a_write_resp_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   a_read_answered: assert property (arTake |=> rvalid && !arready)
      else $error("read not answered");
   a_read_resp_once: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read response repeated");
   a_reserved_zero: assert property (rvalid |-> rdata[31:8] == '0)
      else $error("upper read bits not zero");
   a_pin_needs_match: assert property ($changed(chanYOutputPin) |-> $past(yEqual) || $past(yEqual, 2))
      else $error("pin moved without a match");
   a_irq_req_cause: assert property ($changed(captureIrqRequest) |->
      $past(bvalid) || ($past(externalResetInput, 3) && !$past(externalResetInput, 2)))
      else $error("capture request moved without cause");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(arTake) || bvalid || $past(bvalid))
      else $error("interrupt dropped without access");
   a_match_c_gap: assert property ($rose(bvalid) && lastAwAddr == COMPARE_C_OFFSET |-> !matchCSignal)
      else $error("match C not suppressed during constant write");
endmodule : tscc_timer_status_capture_compare_checker
`default_nettype wire

// [tb/tscc_timer_status_capture_compare_bench.sv]
// Self-checking bench for the timer status, capture and compare block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
bind tscc_timer_status_capture_compare tscc_timer_status_capture_compare_checker u_checker
(
   .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .chanYCounter(chanYCounter), .chanYConstantA(chanYConstantA),
   .chanYConstantB(chanYConstantB), .externalResetInput(externalResetInput),
   .chanYOutputPin(chanYOutputPin), .captureIrqRequest(captureIrqRequest), .matchCSignal(matchCSignal), .irq(irq)
);
module tscc_timer_status_capture_compare_bench;
   import tscc_pkg::*;
   localparam logic [15:0] CODE_SEQ = 16'hE1D2;
   localparam logic [23:0] EV_V1 = 24'hFF_8040;
   localparam logic [23:0] EV_V2 = 24'h00_1010;
   localparam logic [23:0] EV_BIT = 24'h20_8040;
   logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, chanXCounter = 8'h00, chanYCounter = 8'h10;
   logic [7:0] chanYConstantA = 8'h40, chanYConstantB = 8'h80;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h1;
   logic externalResetInput = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, chanYOutputPin, captureIrqRequest, matchCSignal, irq;
   logic [1:0] bresp, rresp, resp, code;
   logic [31:0] rdata, readData;
   logic expPin = 1'b0;
   int checked = 0, num_errors = 0;
   tscc_timer_status_capture_compare u_tscc_timer_status_capture_compare
   (
      .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .chanYCounter(chanYCounter), .chanYConstantA(chanYConstantA),
      .chanYConstantB(chanYConstantB), .chanXCounter(chanXCounter), .externalResetInput(externalResetInput),
      .chanYOutputPin(chanYOutputPin), .captureIrqRequest(captureIrqRequest), .matchCSignal(matchCSignal),
      .irq(irq)
   );
   always #50 clk = ~clk;
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      readData = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      rd(a);
      `CHK(nm, 32'(e), readData)
   endtask : rdchk
   // Counter at v1 for one cycle, then at v2 for one cycle, then back to an idle value
   task automatic pulseY(input logic [7:0] v1, input logic [7:0] v2);
      chanYCounter <= v1;
      @(posedge clk);
      chanYCounter <= v2;
      @(posedge clk);
      chanYCounter <= 8'h10;
      repeat (2) @(posedge clk);
   endtask : pulseY
   task automatic capPulse(input logic [7:0] r, input logic [7:0] f);
      chanXCounter <= r;
      externalResetInput <= 1'b1;
      repeat (2) @(posedge clk);
      chanXCounter <= f;
      externalResetInput <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : capPulse
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdchk(TY_STATUS_OFFSET, 8'h00, "status");
      rdchk(COMPARE_C_OFFSET, 8'hFF, "compareC");
      rdchk(CAPTURE_RISE_OFFSET, 8'h00, "rise");
      rdchk(CAPTURE_FALL_OFFSET, 8'h00, "fall");
      wr(CAPTURE_RISE_OFFSET, 32'h0000_00A5);
      rdchk(CAPTURE_RISE_OFFSET, 8'h00, "riseRO");
      wr(COMPARE_C_OFFSET, 32'h0000_005A);
      rdchk(COMPARE_C_OFFSET, 8'h5A, "compareCrw");
      rd(8'h1C);
      `CHK("unmappedResp", RESP_SLVERR, resp)
      `CHK("unmappedData", 32'h0000_0000, readData)
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         code = CODE_SEQ[2 * i +: 2];
         wr(TY_STATUS_OFFSET, (i < 4) ? 32'(code) : (32'(code) << 2));
         pulseY((i < 4) ? chanYConstantA : chanYConstantB, 8'h10);
         expPin = (code == ACTION_LOW) ? 1'b0 : (code == ACTION_HIGH) ? 1'b1 : (code == ACTION_TOGGLE) ? !expPin : expPin;
         `CHK("pin", expPin, chanYOutputPin)
      end
      $display("test pin done");
      rdchk(TY_STATUS_OFFSET, 8'hCC, "flagsAB");
      wr(TY_STATUS_OFFSET, 32'h0000_000C);
      for (int e = 0; e < 3; e++)
      begin
         pulseY(EV_V1[8 * e +: 8], EV_V2[8 * e +: 8]);
         wr(TY_STATUS_OFFSET, 32'h0000_000C);
         rdchk(TY_STATUS_OFFSET, EV_BIT[8 * e +: 8] | 8'h0C, "flagSet");
         wr(TY_STATUS_OFFSET, 32'h0000_000C);
      end
      rdchk(TY_STATUS_OFFSET, 8'h0C, "flagClear");
      wr(TY_STATUS_OFFSET, 32'h0000_00EC);
      rdchk(TY_STATUS_OFFSET, 8'h0C, "flagNoSet");
      $display("test flags done");
      `CHK("irqMasked", 1'b0, irq)
      wr(IRQ_MASK_OFFSET, 32'h0000_001F);
      `CHK("irqHigh", 1'b1, irq)
      rdchk(IRQ_STATUS_OFFSET, 8'h07, "irqStatus");
      `CHK("irqLow", 1'b0, irq)
      $display("test irq done");
      rdchk(CAPTURE_CTRL_OFFSET, 8'h00, "ctrlIdle");
      wr(CAPTURE_CTRL_OFFSET, 32'h0000_0010);
      rdchk(CAPTURE_CTRL_OFFSET, 8'h10, "armed");
      wr(TY_STATUS_OFFSET, 32'h0000_001C);
      capPulse(8'h33, 8'h77);
      `CHK("capReq", 1'b1, captureIrqRequest)
      `CHK("irqCap", 1'b1, irq)
      rdchk(CAPTURE_RISE_OFFSET, 8'h33, "riseCap");
      rdchk(CAPTURE_FALL_OFFSET, 8'h77, "fallCap");
      rdchk(CAPTURE_CTRL_OFFSET, 8'h01, "ctrlDone");
      wr(TY_STATUS_OFFSET, 32'h0000_000C);
      repeat (2) @(posedge clk);
      `CHK("capReqOff", 1'b0, captureIrqRequest)
      wr(TY_STATUS_OFFSET, 32'h0000_001C);
      repeat (2) @(posedge clk);
      `CHK("capReqOn", 1'b1, captureIrqRequest)
      wr(CAPTURE_CTRL_OFFSET, 32'h0000_0000);
      repeat (2) @(posedge clk);
      `CHK("capReqClr", 1'b0, captureIrqRequest)
      rdchk(CAPTURE_CTRL_OFFSET, 8'h00, "flagClr");
      capPulse(8'h44, 8'h55);
      rdchk(CAPTURE_RISE_OFFSET, 8'h33, "noRearm");
      chanXCounter <= 8'h8D;
      @(posedge clk);
      chanXCounter <= 8'h00;
      @(posedge clk);
      `CHK("matchC", 1'b1, matchCSignal)
      @(posedge clk);
      `CHK("matchCEnd", 1'b0, matchCSignal)
      rdchk(IRQ_STATUS_OFFSET, 8'h18, "irqStatus2");
      chanXCounter <= 8'h8D;
      wr(COMPARE_C_OFFSET, 32'h0000_005A);
      `CHK("matchCBack", 1'b1, matchCSignal)
      chanXCounter <= 8'h00;
      $display("test capture done");
      summarize();
   end
endmodule : tscc_timer_status_capture_compare_bench
`default_nettype wire
